// File: src/converter_config_defs.vh
// Purpose: constants for the converter configuration register bank
// Assumes: 16-bit command words, 8-bit command codes
// Notes: definitions only
`ifndef CONVERTER_CONFIG_DEFS_VH
`define CONVERTER_CONFIG_DEFS_VH

// Command codes
`define CMD_USER_FEATURE_CONFIG 8'hD1
`define CMD_PHASE_SHARING_CONFIG 8'hD3
`define CMD_CURRENT_SENSE_CONFIG 8'hD0

// Current sense word fields
`define CS_FAULT_CNT_HI 10
`define CS_FAULT_CNT_LO 8
`define CS_METHOD_HI 3
`define CS_METHOD_LO 2
`define CS_RANGE_HI 1
`define CS_RANGE_LO 0
`define CS_WRITE_MASK 16'hFF0F
`define CS_RESET 16'h0001

// Sensing method codes
`define METHOD_UNUSED 2'h0
`define METHOD_DOWN 2'h1
`define METHOD_UP 2'h2
`define METHOD_STAGE 2'h3

// Sense range codes
`define RANGE_LOW 2'h0
`define RANGE_MED 2'h1
`define RANGE_HIGH 2'h2

// User configuration word fields
`define UC_MIN_DUTY_HI 15
`define UC_MIN_DUTY_LO 11
`define UC_NOT_USED_10 10
`define UC_MIN_DUTY_EN 7
`define UC_STRAP_SEL 5
`define UC_LOW_SIDE_STATE 3
`define UC_PG_PUSH_PULL 2
`define UC_EXTERNAL_TEMP_SENSOR_EN 1
`define UC_EXTERNAL_TEMP_SENSOR_FAULT 0
`define UC_WRITE_MASK 16'hF8AF
`define UC_FIXED_BITS 16'h0400

// Phase sharing word fields
`define PS_PHASE_ID_HI 15
`define PS_PHASE_ID_LO 13
`define PS_RAIL_ID_HI 12
`define PS_RAIL_ID_LO 8
`define PS_PHASES_HI 2
`define PS_PHASES_LO 0
`define PS_WRITE_MASK 16'hFF07

// Fault counter width
`define FAULT_CNT_W 4

`endif

// File: src/converter_config_registers.v
// Purpose: configuration register bank of a multi-phase converter controller
// Assumes: command write/read port is already decoded from the bus host
// Notes: user and phase defaults come from straps sampled after reset release
//
// Behaviour
// - Fault count code n means 2n+1 consecutive events, 1 through 15.
// - Fault declared only after that many consecutive cycles, one event each.
// - Method field 01 down slope, 10 up slope, 11 stage monitor.
// - Range field 00 25 mV, 01 35 mV, 10 50 mV, 11 unused.
// - Minimum duty is 2*(value+1)/512, applied only while enabled.
// - Bit 7 enables the minimum duty limit.
// - Bit 5 selects which voltage strap pin sets output voltage.
// - Bit 3 gives low-side drive level while disabled.
// - Bit 2 selects push-pull, else open-drain power-good.
// - Bit 1 enables the external temperature sensor input.
// - Bit 0 bases temperature faults on the external sensor.
// - User word default comes from the configuration strap.
// - Phase ID in bits 15:13, values 0 to 7, default 0.
// - Rail ID in bits 12:8, values 0 to 31.
// - Bits 2:0 hold phases in rail minus one.
// - Phases of a rail are spread at equal offsets automatically.
// - Phase word resets to address low five bits in rail field.
// - With strap in use the phase word comes from the strap.
`timescale 1ns/1ps
`include "converter_config_defs.vh"
module converter_config_registers #(
  parameter PHASE_W = 9
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Command port
  input wire cmd_wr,
  input wire cmd_rd,
  input wire [7:0] cmd_code,
  input wire [15:0] cmd_wdata,
  // Pin straps
  input wire [15:0] cfg_strap_user,
  input wire cfg_strap_used,
  input wire [15:0] cfg_strap_phase,
  input wire [6:0] bus_address,
  input wire [15:0] voltage_strap_pin_a,
  input wire [15:0] voltage_strap_pin_b,
  // Operating state
  input wire device_enabled,
  input wire pwm_low_side,
  input wire power_good,
  input wire cycle_tick,
  input wire overcurrent_event,
  input wire undercurrent_event,
  input wire external_temp_sensor,
  input wire internal_temp_fault,
  // Command answer
  output reg [15:0] cmd_rdata_q,
  output reg cmd_rvalid_q,
  output reg cmd_ack_q,
  // Decoded controls
  output reg [9:0] min_duty_num_q,
  output reg min_duty_en_q,
  output reg [15:0] vout_strap_q,
  output reg [1:0] sense_method_q,
  output reg [1:0] sense_range_q,
  output reg [5:0] sense_mv_q,
  output reg current_fault_q,
  output reg temp_fault_q,
  // Multi-phase
  output reg [2:0] phase_id_q,
  output reg [4:0] rail_id_q,
  output reg [3:0] phase_count_q,
  output reg [PHASE_W-1:0] phase_offset_q,
  // Pins
  output reg low_side_drive_out_q,
  output reg power_good_out_q,
  output reg power_good_oe_q,
  output reg external_temp_en_q
);
  // ****************************************
  // Register state
  // ****************************************
  reg [15:0] user_feature_config_q;
  reg [15:0] phase_sharing_config_q;
  reg [15:0] current_sense_config_q;
  reg strap_pending_q;
  wire [3:0] fault_needed;
  wire oc_fault;
  wire uc_fault;
  wire [2:0] phases_m1;
  wire [2:0] pid;
  wire [5:0] duty_step;
  wire [PHASE_W+2:0] offset_num;
  wire [PHASE_W+2:0] offset_den;
  wire [PHASE_W+2:0] offset_quo;
  reg [PHASE_W-1:0] offset_d;
  reg [15:0] rdata_d;
  reg hit_d;

  // ****************************************
  // Command writes and strap defaults
  // ****************************************
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      user_feature_config_q <= `UC_FIXED_BITS;
      phase_sharing_config_q <= 16'h0000;
      current_sense_config_q <= `CS_RESET;
      strap_pending_q <= 1'b1;
    end else if (strap_pending_q) begin
      // Straps are sampled once after release, never under reset
      strap_pending_q <= 1'b0;
      user_feature_config_q <= (cfg_strap_user & `UC_WRITE_MASK) | `UC_FIXED_BITS;
      if (cfg_strap_used) begin
        phase_sharing_config_q <= cfg_strap_phase & `PS_WRITE_MASK;
      end else begin
        phase_sharing_config_q <= {3'h0, bus_address[4:0], 8'h00};
      end
    end else if (cmd_wr) begin
      case (cmd_code)
        `CMD_USER_FEATURE_CONFIG: begin
          user_feature_config_q <= (cmd_wdata & `UC_WRITE_MASK) | `UC_FIXED_BITS;
        end
        `CMD_PHASE_SHARING_CONFIG: begin
          phase_sharing_config_q <= cmd_wdata & `PS_WRITE_MASK;
        end
        `CMD_CURRENT_SENSE_CONFIG: begin
          current_sense_config_q <= cmd_wdata & `CS_WRITE_MASK;
        end
        default: begin
          current_sense_config_q <= current_sense_config_q;
        end
      endcase
    end
  end

  // ****************************************
  // Command reads
  // ****************************************
  always @* begin
    rdata_d = 16'h0000;
    hit_d = 1'b1;
    case (cmd_code)
      `CMD_USER_FEATURE_CONFIG: rdata_d = user_feature_config_q;
      `CMD_PHASE_SHARING_CONFIG: rdata_d = phase_sharing_config_q;
      `CMD_CURRENT_SENSE_CONFIG: rdata_d = current_sense_config_q;
      default: hit_d = 1'b0;
    endcase
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cmd_rdata_q <= 16'h0000;
      cmd_rvalid_q <= 1'b0;
      cmd_ack_q <= 1'b0;
    end else begin
      // The strap edge drops commands, so it must not answer them either
      cmd_rvalid_q <= cmd_rd & hit_d & ~strap_pending_q;
      cmd_ack_q <= (cmd_rd | cmd_wr) & hit_d & ~strap_pending_q;
      if (cmd_rd) begin
        cmd_rdata_q <= rdata_d;
      end
    end
  end

  // ****************************************
  // Current sense fault timing
  // ****************************************
  assign fault_needed = {current_sense_config_q[`CS_FAULT_CNT_HI:`CS_FAULT_CNT_LO], 1'b1};

  fault_event_counter #(
    .CNT_W(`FAULT_CNT_W)
  ) u_oc_count (
    .clk(clk),
    .rst(rst),
    .cycle_tick(cycle_tick),
    .event_in(overcurrent_event),
    .needed(fault_needed),
    .fault_q(oc_fault)
  );

  fault_event_counter #(
    .CNT_W(`FAULT_CNT_W)
  ) u_uc_count (
    .clk(clk),
    .rst(rst),
    .cycle_tick(cycle_tick),
    .event_in(undercurrent_event),
    .needed(fault_needed),
    .fault_q(uc_fault)
  );

  // ****************************************
  // Phase spreading
  // ****************************************
  assign phases_m1 = phase_sharing_config_q[`PS_PHASES_HI:`PS_PHASES_LO];
  assign pid = phase_sharing_config_q[`PS_PHASE_ID_HI:`PS_PHASE_ID_LO];

  // Offset is a fraction of the switching period, full scale 2^PHASE_W
  assign offset_num = {pid, {PHASE_W{1'b0}}};
  assign offset_den = {{PHASE_W{1'b0}}, phases_m1} + {{(PHASE_W+2){1'b0}}, 1'b1};
  assign offset_quo = offset_num / offset_den;

  // An ID beyond the rail size has no slot, so it gets no offset
  always @* begin
    offset_d = {PHASE_W{1'b0}};
    if (pid <= phases_m1) begin
      offset_d = offset_quo[PHASE_W-1:0];
    end
  end

  // ****************************************
  // Decoded outputs
  // ****************************************
  // Numerator over 512 is twice (field plus one); six bits hold the largest step
  assign duty_step = {1'b0, user_feature_config_q[`UC_MIN_DUTY_HI:`UC_MIN_DUTY_LO]} + 6'h01;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      min_duty_num_q <= 10'h000;
      min_duty_en_q <= 1'b0;
      vout_strap_q <= 16'h0000;
      sense_method_q <= `METHOD_UNUSED;
      sense_range_q <= `RANGE_LOW;
      sense_mv_q <= 6'h00;
      current_fault_q <= 1'b0;
      temp_fault_q <= 1'b0;
      external_temp_en_q <= 1'b0;
    end else begin
      // Zero while the limit is off
      min_duty_en_q <= user_feature_config_q[`UC_MIN_DUTY_EN];
      if (user_feature_config_q[`UC_MIN_DUTY_EN]) begin
        min_duty_num_q <= {3'h0, duty_step, 1'b0};
      end else begin
        min_duty_num_q <= 10'h000;
      end
      vout_strap_q <= user_feature_config_q[`UC_STRAP_SEL] ? voltage_strap_pin_b : voltage_strap_pin_a;
      sense_method_q <= current_sense_config_q[`CS_METHOD_HI:`CS_METHOD_LO];
      sense_range_q <= current_sense_config_q[`CS_RANGE_HI:`CS_RANGE_LO];
      case (current_sense_config_q[`CS_RANGE_HI:`CS_RANGE_LO])
        `RANGE_LOW: sense_mv_q <= 6'h19;
        `RANGE_MED: sense_mv_q <= 6'h23;
        `RANGE_HIGH: sense_mv_q <= 6'h32;
        default: sense_mv_q <= 6'h00;
      endcase
      current_fault_q <= oc_fault | uc_fault;
      external_temp_en_q <= user_feature_config_q[`UC_EXTERNAL_TEMP_SENSOR_EN];
      if (user_feature_config_q[`UC_EXTERNAL_TEMP_SENSOR_FAULT]) begin
        temp_fault_q <= external_temp_sensor;
      end else begin
        temp_fault_q <= internal_temp_fault;
      end
    end
  end

  // ****************************************
  // Multi-phase outputs
  // ****************************************
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      phase_id_q <= 3'h0;
      rail_id_q <= 5'h00;
      phase_count_q <= 4'h1;
      phase_offset_q <= {PHASE_W{1'b0}};
    end else begin
      phase_id_q <= pid;
      rail_id_q <= phase_sharing_config_q[`PS_RAIL_ID_HI:`PS_RAIL_ID_LO];
      phase_count_q <= {1'b0, phases_m1} + 4'h1;
      phase_offset_q <= offset_d;
    end
  end

  // ****************************************
  // Pin drivers
  // ****************************************
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      low_side_drive_out_q <= 1'b0;
      power_good_out_q <= 1'b0;
      power_good_oe_q <= 1'b0;
    end else begin
      if (device_enabled) begin
        low_side_drive_out_q <= pwm_low_side;
      end else begin
        low_side_drive_out_q <= user_feature_config_q[`UC_LOW_SIDE_STATE];
      end
      power_good_out_q <= power_good;
      // Open drain only ever drives the low level; the pull-up gives the high one
      if (user_feature_config_q[`UC_PG_PUSH_PULL]) begin
        power_good_oe_q <= 1'b1;
      end else begin
        power_good_oe_q <= ~power_good;
      end
    end
  end
endmodule // converter_config_registers

// File: src/fault_event_counter.v
// Purpose: counts consecutive switching cycles with a current event
// Assumes: cycle_tick pulses once per switching cycle
// Notes: at most one event is taken per switching cycle
`timescale 1ns/1ps
module fault_event_counter #(
  parameter CNT_W = 4
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Switching cycle and event
  input wire cycle_tick,
  input wire event_in,
  input wire [CNT_W-1:0] needed,
  // Result
  output reg fault_q
);
  reg seen_q;
  reg [CNT_W-1:0] run_q;
  wire [CNT_W-1:0] run_inc;

  assign run_inc = run_q + {{(CNT_W-1){1'b0}}, 1'b1};

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      seen_q <= 1'b0;
      run_q <= {CNT_W{1'b0}};
      fault_q <= 1'b0;
    end else begin
      // Latch the event until the cycle closes; repeats count once
      if (cycle_tick) begin
        seen_q <= 1'b0;
        if (seen_q || event_in) begin
          // A run held at full scale would wrap on increment, so the held count trips as well
          if (run_q >= needed || run_inc >= needed) begin
            fault_q <= 1'b1;
            run_q <= needed;
          end else begin
            run_q <= run_inc;
          end
        end else begin
          run_q <= {CNT_W{1'b0}};
          fault_q <= 1'b0;
        end
      end else if (event_in) begin
        seen_q <= 1'b1;
      end
    end
  end
endmodule // fault_event_counter

// File: verif/cfg_asserts.sv
// Purpose: port checks for the config register bank
// Assumes: one clock, async active-high reset
// Notes: bound from the testbench file
`timescale 1ns/1ps
`include "converter_config_defs.vh"
module cfg_asserts #(
  parameter PHASE_W = 9
) (
  // Clock, reset, commands
  input wire clk,
  input wire rst,
  input wire cmd_wr,
  input wire cmd_rd,
  input wire [7:0] cmd_code,
  input wire cmd_ack_q,
  input wire cmd_rvalid_q,
  // Decoded outputs
  input wire [9:0] min_duty_num_q,
  input wire min_duty_en_q,
  input wire [1:0] sense_range_q,
  input wire [5:0] sense_mv_q,
  input wire [2:0] phase_id_q,
  input wire [3:0] phase_count_q,
  input wire [PHASE_W-1:0] phase_offset_q,
  input wire power_good_out_q,
  input wire power_good_oe_q,
  input wire current_fault_q,
  input wire cycle_tick
);
  wire mapped = cmd_code == `CMD_USER_FEATURE_CONFIG || cmd_code == `CMD_PHASE_SHARING_CONFIG ||
    cmd_code == `CMD_CURRENT_SENSE_CONFIG;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // The first edge after release only loads the straps and answers nothing
  sequence s_cmd; (cmd_wr || cmd_rd) && mapped && !$past(rst); endsequence
  sequence s_stray; (cmd_wr || cmd_rd) && !mapped; endsequence
  property p_ack; s_cmd |=> cmd_ack_q; endproperty
  a_ack: assert property (p_ack) else $error("command not acknowledged");
  property p_stray; s_stray |=> !cmd_ack_q && !cmd_rvalid_q; endproperty
  a_stray: assert property (p_stray) else $error("unmapped code answered");
  property p_rvalid; cmd_rvalid_q |-> $past(cmd_rd) && cmd_ack_q; endproperty
  a_rvalid: assert property (p_rvalid) else $error("read valid without read");
  property p_duty; min_duty_en_q ? !min_duty_num_q[0] && min_duty_num_q != 10'h000 && min_duty_num_q <= 10'h040 :
    min_duty_num_q == 10'h000; endproperty
  a_duty: assert property (p_duty) else $error("minimum duty value wrong");
  // Decoded pairs settle one edge after release, so that edge is skipped
  property p_range; !$past(rst) |-> sense_mv_q == (sense_range_q == 2'h0 ? 6'h19 :
    sense_range_q == 2'h1 ? 6'h23 : sense_range_q == 2'h2 ? 6'h32 : 6'h00); endproperty
  a_range: assert property (p_range) else $error("sense range decode wrong");
  property p_pg; !$past(rst) && !power_good_oe_q |-> power_good_out_q; endproperty
  a_pg: assert property (p_pg) else $error("open drain drives low level");
  property p_offset; phase_id_q >= phase_count_q |-> phase_offset_q == 0; endproperty
  a_offset: assert property (p_offset) else $error("offset for absent phase");
  property p_fault; $rose(current_fault_q) |-> $past(cycle_tick, 2) || $past(cycle_tick, 3); endproperty
  a_fault: assert property (p_fault) else $error("fault not tied to a cycle");
endmodule // cfg_asserts

// File: verif/phase_partner.sv
// Purpose: far side model giving switching cycles and current events
// Assumes: six clocks per switching cycle
// Notes: events pulse once per cycle, never more
`timescale 1ns/1ps
module phase_partner (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Scenario control
  input wire oc_on,
  input wire uc_on,
  // Switching cycle outputs
  output reg cycle_tick,
  output reg overcurrent_event,
  output reg undercurrent_event
);
  reg [2:0] phase_q;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      phase_q <= 3'h0;
      cycle_tick <= 1'b0;
      overcurrent_event <= 1'b0;
      undercurrent_event <= 1'b0;
    end else begin
      phase_q <= (phase_q == 3'h5) ? 3'h0 : phase_q + 3'h1;
      cycle_tick <= phase_q == 3'h5;
      overcurrent_event <= oc_on && phase_q == 3'h2;
      undercurrent_event <= uc_on && phase_q == 3'h2;
    end
  end
endmodule // phase_partner

// File: verif/testbench.sv
// Purpose: self-checking bench for the config register bank
// Assumes: tasks act as host, phase_partner as far side
// Notes: reset is repeated to try the phase strap
`timescale 1ns/1ps
`include "converter_config_defs.vh"
module testbench;
  localparam [7:0] uc_cmd = `CMD_USER_FEATURE_CONFIG;
  localparam [7:0] ps_cmd = `CMD_PHASE_SHARING_CONFIG;
  localparam [7:0] cs_cmd = `CMD_CURRENT_SENSE_CONFIG;
  reg clk = 1'b0, rst = 1'b1, cmd_wr = 1'b0, cmd_rd = 1'b0, used = 1'b0, en = 1'b0, ext = 1'b0, itf = 1'b1;
  reg oc_on = 1'b0, uc_on = 1'b0, pg = 1'b1;
  reg [7:0] cmd_code = 8'h00;
  reg [15:0] cmd_wdata = 16'h0000, pin_a = 16'h1234, pin_b = 16'hABCD, w;
  reg [1:0] r;
  integer i, bad_count = 0, cmp_count = 0;
  wire cycle_tick, overcurrent_event, undercurrent_event, cmd_rvalid_q, cmd_ack_q, min_duty_en_q;
  wire current_fault_q, temp_fault_q, low_side_drive_out_q, power_good_out_q, power_good_oe_q, external_temp_en_q;
  wire [15:0] cmd_rdata_q, vout_strap_q;
  wire [9:0] min_duty_num_q;
  wire [1:0] sense_method_q, sense_range_q;
  wire [5:0] sense_mv_q;
  wire [2:0] phase_id_q;
  wire [4:0] rail_id_q;
  wire [3:0] phase_count_q;
  wire [8:0] phase_offset_q;
  always #12.5 clk = ~clk;
  converter_config_registers i_dut (.clk, .rst, .cmd_wr, .cmd_rd, .cmd_code, .cmd_wdata,
    .cfg_strap_user(16'h00A5), .cfg_strap_used(used), .cfg_strap_phase(16'hFFFF), .bus_address(7'h5B),
    .voltage_strap_pin_a(pin_a), .voltage_strap_pin_b(pin_b), .device_enabled(en), .pwm_low_side(1'b1),
    .power_good(pg), .cycle_tick, .overcurrent_event, .undercurrent_event, .external_temp_sensor(ext),
    .internal_temp_fault(itf), .cmd_rdata_q, .cmd_rvalid_q, .cmd_ack_q, .min_duty_num_q, .min_duty_en_q,
    .vout_strap_q, .sense_method_q, .sense_range_q, .sense_mv_q, .current_fault_q, .temp_fault_q,
    .phase_id_q, .rail_id_q, .phase_count_q, .phase_offset_q, .low_side_drive_out_q, .power_good_out_q,
    .power_good_oe_q, .external_temp_en_q);
  phase_partner i_far (.clk, .rst, .oc_on, .uc_on, .cycle_tick, .overcurrent_event, .undercurrent_event);
  task chk(input [15:0] g, input [15:0] e);
    cmp_count = cmp_count + 1;
    if (g !== e) begin
      bad_count = bad_count + 1;
      $display("FAIL %0t got %h expected %h", $time, g, e);
    end
  endtask
  task cmd(input w_en, input [7:0] c, input [15:0] d);
    @(posedge clk);
    cmd_wr <= w_en;
    cmd_rd <= !w_en;
    cmd_code <= c;
    cmd_wdata <= d;
    @(posedge clk);
    cmd_wr <= 1'b0;
    cmd_rd <= 1'b0;
    #1;
  endtask
  task wr(input [7:0] c, input [15:0] d);
    cmd(1'b1, c, d);
    chk(cmd_ack_q, 16'h0001);
    // Decoded outputs trail the register by one edge
    repeat (2) @(posedge clk);
    #1;
  endtask
  task rd(input [7:0] c, input [15:0] e);
    cmd(1'b0, c, 16'h0000);
    chk(cmd_ack_q & cmd_rvalid_q, 16'h0001);
    chk(cmd_rdata_q, e);
  endtask
  task do_reset;
    @(posedge clk);
    rst <= 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  // ********************
  // Scenarios
  // ********************
  task t_user;
    for (i = 0; i < 2; i = i + 1) begin
      w = i ? 16'h0000 : 16'hFFFF;
      // Read back straight after each write, the point at which a host stores the word
      wr(uc_cmd, w);
      rd(uc_cmd, w & 16'hF8AF | 16'h0400);
      chk(min_duty_num_q, w[7] ? ({5'h00, w[15:11]} + 10'h001) << 1 : 10'h000);
      chk(min_duty_en_q, w[7]);
      chk(vout_strap_q, w[5] ? pin_b : pin_a);
      chk(low_side_drive_out_q, w[3]);
      chk(power_good_oe_q, w[2]);
      chk(power_good_out_q, 16'h0001);
      chk(external_temp_en_q, w[1]);
      chk(temp_fault_q, w[0] ? ext : itf);
    end
    @(posedge clk);
    en <= 1'b1;
    pg <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk(low_side_drive_out_q, 16'h0001);
    chk({power_good_oe_q, power_good_out_q}, 16'h0002);
    @(posedge clk);
    en <= 1'b0;
    pg <= 1'b1;
    $display("user word test done");
  endtask
  task t_sense;
    for (i = 0; i < 4; i = i + 1) begin
      r = ~i[1:0];
      w = {5'h00, i[2:0], 4'h0, i[1:0], r};
      wr(cs_cmd, w);
      rd(cs_cmd, w);
      chk(sense_method_q, i[1:0]);
      chk(sense_range_q, r);
      chk(sense_mv_q, r == 2'h0 ? 6'h19 : r == 2'h1 ? 6'h23 : r == 2'h2 ? 6'h32 : 6'h00);
    end
    $display("sense word test done");
  endtask
  task t_phase;
    for (i = 0; i < 5; i = i + 1) begin
      case (i)
        0: w = 16'h0501;
        1: w = 16'h2501;
        2: w = 16'h4503;
        3: w = 16'h6001;
        default: w = 16'hFFFF;
      endcase
      wr(ps_cmd, w);
      rd(ps_cmd, w & 16'hFF07);
      chk(phase_id_q, w[15:13]);
      chk(rail_id_q, w[12:8]);
      chk(phase_count_q, w[2:0] + 4'h1);
      chk(phase_offset_q, (w[15:13] > w[2:0]) ? 12'h000 : {w[15:13], 9'h000} / (w[2:0] + 4'h1));
    end
    $display("phase word test done");
  endtask
  task t_fault;
    wr(cs_cmd, 16'h0100);
    @(posedge clk);
    uc_on <= 1'b1;
    // Twelve clocks give exactly two events, one short of three; watch every cycle
    for (i = 1; i <= 36; i = i + 1) begin
      @(posedge clk);
      if (i == 12) begin
        uc_on <= 1'b0;
      end
      #1;
      chk(current_fault_q, 16'h0000);
    end
    @(posedge clk);
    oc_on <= 1'b1;
    repeat (30) @(posedge clk);
    #1;
    chk(current_fault_q, 16'h0001);
    @(posedge clk);
    oc_on <= 1'b0;
    repeat (24) @(posedge clk);
    #1;
    chk(current_fault_q, 16'h0000);
    $display("fault count test done");
  endtask
  task t_other;
    cmd(1'b1, 8'hD2, 16'hFFFF);
    chk(cmd_ack_q, 16'h0000);
    cmd(1'b0, 8'hD2, 16'h0000);
    chk(cmd_rdata_q, 16'h0000);
    chk(cmd_ack_q | cmd_rvalid_q, 16'h0000);
    @(posedge clk);
    used <= 1'b1;
    do_reset;
    rd(ps_cmd, 16'hFF07);
    $display("unmapped and strap test done");
  endtask
  task complete_run;
    $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    #100000;
    bad_count = bad_count + 1;
    $display("FAIL %0t watchdog expired", $time);
    complete_run;
  end
  initial begin
    do_reset;
    rd(uc_cmd, 16'h04A5);
    rd(ps_cmd, 16'h1B00);
    rd(cs_cmd, `CS_RESET);
    $display("defaults test done");
    t_user;
    t_sense;
    t_phase;
    t_fault;
    t_other;
    complete_run;
  end
endmodule // testbench
bind converter_config_registers cfg_asserts #(.PHASE_W(PHASE_W)) i_chk (.clk, .rst, .cmd_wr, .cmd_rd,
  .cmd_code, .cmd_ack_q, .cmd_rvalid_q, .min_duty_num_q, .min_duty_en_q, .sense_range_q, .sense_mv_q,
  .phase_id_q, .phase_count_q, .phase_offset_q, .power_good_out_q, .power_good_oe_q, .current_fault_q,
  .cycle_tick);
